// File: rtl/cpmc_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - strap level picks port or auto-detect
// - auto-detect: power only, switch open
// - auto-detect entry starts in divider state
// - divider state biases both lines 2.7V
// - compliant client: shorted briefly, then 1.2V
// - shorted state joins lines, low impedance
// - 1.2V state: joined lines biased 1.2V
// - charging port presents handshake signature
// - fall back from charging to standard port
module cpmc_mode_ctrl
	import cpmc_pkg::*;
#(
	parameter int FALLBACK_CYCLES = FALLBACK_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire cpmc_pins_t pins,
	output var cpmc_line_t line_ctrl,
	output logic vbus_en,
	output var cpmc_det_t det_state,
	output var cpmc_port_t port_state
);

	localparam int SHORT_W = $clog2(SHORT_CYC + 1);
	localparam int FB_W = $clog2(FALLBACK_CYCLES + 1);
	localparam logic [SHORT_W-1:0] SHORT_LAST = SHORT_W'(SHORT_CYC - 1);
	localparam logic [FB_W-1:0] FB_LAST = FB_W'(FALLBACK_CYCLES - 1);
	localparam int HOLD_MAX = SHORT_CYC;

	cpmc_pins_t sync_s;
	logic mode_auto_q;
	cpmc_det_t det_q;
	cpmc_port_t port_q;
	logic [SHORT_W-1:0] short_cnt_q;
	logic [FB_W-1:0] fb_cnt_q;
	cpmc_line_t line_q;
	cpmc_line_t line_d;
	logic vbus_en_q;
	logic vbus_en_d;
	logic attach_s;

	cpmc_sync u_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.pins_in(pins),
		.pins_out(sync_s)
	);

	assign attach_s = sync_s.client_attach;

	// strap level picks mode
	// followed live, so a strap change re-enters the chosen mode cleanly
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mode_auto_q <= 1'b0;
		else
			mode_auto_q <= (sync_s.charge_mode_select == STRAP_AUTO);
	end

	// divider first on entry
	// outside auto-detect the machine parks in divider, so entry starts there
	always_ff @(posedge clk)
	begin
		if (!rst_n || !mode_auto_q || !attach_s)
			det_q <= DET_DIVIDER;
		else
		begin
			case (det_q)
				DET_DIVIDER:
					if (sync_s.client_resp)
						det_q <= DET_SHORTED;
				DET_SHORTED:
					if (short_cnt_q == SHORT_LAST)
						det_q <= DET_SHORT12;
				DET_SHORT12:
					det_q <= DET_SHORT12;
				default:
					det_q <= DET_DIVIDER;
			endcase
		end
	end

	// shorted interval counter, idle at zero elsewhere
	always_ff @(posedge clk)
	begin
		if (!rst_n || det_q != DET_SHORTED || !mode_auto_q || !attach_s)
			short_cnt_q <= '0;
		else
			short_cnt_q <= short_cnt_q + 1'b1;
	end

	// fallback to standard port
	// a client that saw a dedicated port never starts data; give it one
	always_ff @(posedge clk)
	begin
		if (!rst_n || mode_auto_q || !attach_s)
			port_q <= PORT_CHG;
		else
		begin
			case (port_q)
				PORT_CHG:
					if (fb_cnt_q == FB_LAST)
						port_q <= PORT_STD;
				PORT_STD:
					port_q <= PORT_STD;
				default:
					port_q <= PORT_CHG;
			endcase
		end
	end

	// data activity restarts the wait; standard holds until detach
	always_ff @(posedge clk)
	begin
		if (!rst_n || mode_auto_q || !attach_s || sync_s.data_seen
			|| port_q != PORT_CHG)
			fb_cnt_q <= '0;
		else
			fb_cnt_q <= fb_cnt_q + 1'b1;
	end

	// line control decode from current state
	always_comb
	begin
		line_d = LINE_RST;
		if (mode_auto_q)
		begin
			line_d.data_sw_on = 1'b0;
			case (det_q)
				DET_DIVIDER:
					line_d.bias_2v7 = 1'b1;
				DET_SHORTED:
					line_d.lines_short = 1'b1;
				DET_SHORT12:
				begin
					line_d.lines_short = 1'b1;
					line_d.bias_1v2 = 1'b1;
				end
				default:
					line_d.bias_2v7 = 1'b1;
			endcase
		end
		else
		begin
			line_d.data_sw_on = 1'b1;
			line_d.host_chg_sig = (port_q == PORT_CHG);
		end
	end

	// charging needs active host
	// auto-detect supplies power regardless of the upstream side
	assign vbus_en_d = mode_auto_q ? 1'b1 : sync_s.host_active;

	// registered outputs keep the analog controls glitch free
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			line_q <= LINE_RST;
			vbus_en_q <= 1'b0;
		end
		else
		begin
			line_q <= line_d;
			vbus_en_q <= vbus_en_d;
		end
	end

	assign line_ctrl = line_q;
	assign vbus_en = vbus_en_q;
	assign det_state = det_q;
	assign port_state = port_q;

	auto_iso_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_auto_q |=> !line_q.data_sw_on && vbus_en_q)
		else $error("auto-detect left switch closed or power off");

	div_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(mode_auto_q) |-> det_q == DET_DIVIDER ##1 line_q.bias_2v7)
		else $error("auto-detect entry not in divider state");

	div_bias_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_auto_q && det_q == DET_DIVIDER
		|=> line_q.bias_2v7 && !line_q.lines_short && !line_q.bias_1v2)
		else $error("divider state without 2.7V bias");

	short_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(det_q == DET_SHORTED) |-> ##[1:HOLD_MAX] det_q != DET_SHORTED)
		else $error("shorted state held too long");

	// exit to 1.2V only after full interval
	short_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(det_q == DET_SHORT12) |-> $past(short_cnt_q) == SHORT_LAST)
		else $error("1.2V state entered early");

	short_join_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_auto_q && det_q == DET_SHORTED
		|=> line_q.lines_short && !line_q.bias_2v7 && !line_q.bias_1v2)
		else $error("shorted state lines not joined");

	s12_bias_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode_auto_q && det_q == DET_SHORT12
		|=> line_q.lines_short && line_q.bias_1v2)
		else $error("1.2V state without joined bias");

	chg_sig_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_auto_q && port_q == PORT_CHG
		|=> line_q.host_chg_sig && line_q.data_sw_on)
		else $error("charging port without handshake signature");

	host_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_auto_q && !sync_s.host_active |=> !vbus_en_q)
		else $error("port powered while host inactive");

	fallback_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(port_q == PORT_STD)
		|-> $past(fb_cnt_q) == FB_LAST ##1 !line_q.host_chg_sig)
		else $error("fallback timing wrong");

	detach_a: assert property (@(posedge clk) disable iff (!rst_n)
		!attach_s |=> det_q == DET_DIVIDER && port_q == PORT_CHG)
		else $error("detach did not restart detection");

endmodule

`default_nettype wire

// File: rtl/cpmc_pkg.sv
`default_nettype none

package cpmc_pkg;

	// clock rate and the brief shorted-signature interval
	localparam int CLK_MHZ = 50;
	localparam int SHORT_NS = 10000;
	// least time, so round up to whole cycles
	localparam int SHORT_CYC = (SHORT_NS * CLK_MHZ + 999) / 1000;
	// wait for data activity before falling back to a plain port
	localparam int FALLBACK_US = 2000;
	localparam int FALLBACK_CYC = FALLBACK_US * CLK_MHZ;

	// strap level that picks dedicated-charging auto-detect
	localparam logic STRAP_AUTO = 1'b1;

	// auto-detect signature states
	typedef enum logic [1:0]
	{
		DET_DIVIDER,
		DET_SHORTED,
		DET_SHORT12
	} cpmc_det_t;

	// downstream port flavour while the data switch is closed
	typedef enum logic
	{
		PORT_CHG,
		PORT_STD
	} cpmc_port_t;

	// raw pin and comparator levels, all asynchronous to clk
	typedef struct packed
	{
		logic charge_mode_select;
		logic client_attach;
		logic client_resp;
		logic host_active;
		logic data_seen;
	} cpmc_pins_t;

	// analog line controls toward the switch and bias network
	typedef struct packed
	{
		logic data_sw_on;
		logic lines_short;
		logic bias_2v7;
		logic bias_1v2;
		logic host_chg_sig;
	} cpmc_line_t;

	localparam cpmc_line_t LINE_RST = '{default: 1'b0};
	localparam cpmc_pins_t PINS_RST = '{default: 1'b0};

endpackage

`default_nettype wire

// File: rtl/cpmc_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser, one per bit
module cpmc_sync
	import cpmc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire cpmc_pins_t pins_in,
	output var cpmc_pins_t pins_out
);

	cpmc_pins_t meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta_q <= PINS_RST;
			pins_out <= PINS_RST;
		end
		else
		begin
			meta_q <= pins_in;
			pins_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

// File: verification/cpmc_client.sv
`timescale 1ns/10ps
`default_nettype none

// behavioural portable device on the data lines
module cpmc_client
	import cpmc_pkg::*;
(
	input wire logic clk,
	input wire logic plug,
	input wire logic compliant,
	input wire logic talk,
	input wire cpmc_line_t line_ctrl,
	output logic attach,
	output logic resp,
	output logic data
);
	// presence follows the cable
	always_ff @(posedge clk)
		attach <= plug;
	// compliant client reply
	// answers the divider only, a plain client stays silent
	always_ff @(posedge clk)
		resp <= plug & compliant & line_ctrl.bias_2v7;
	// traffic needs closed switch
	// toggles so activity never looks like one held level
	always_ff @(posedge clk)
		data <= plug & talk & line_ctrl.data_sw_on & ~data;
endmodule

`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import cpmc_pkg::*;
	localparam int FB = 50;
	logic clk, rst_n, strap, host, plug, compliant, talk;
	logic attach, resp, data, vbus_en;
	cpmc_pins_t pins;
	cpmc_line_t line_ctrl;
	cpmc_det_t det_state;
	cpmc_port_t port_state;
	int failures, n_compared, cyc;

	// pins gathered as the block sees them
	assign pins = '{strap, attach, resp, host, data};

	cpmc_mode_ctrl #(.FALLBACK_CYCLES(FB)) u_dut (.clk(clk), .rst_n(rst_n),
		.pins(pins), .line_ctrl(line_ctrl), .vbus_en(vbus_en),
		.det_state(det_state), .port_state(port_state));

	cpmc_client u_client (.clk(clk), .plug(plug), .compliant(compliant),
		.talk(talk), .line_ctrl(line_ctrl), .attach(attach), .resp(resp),
		.data(data));

	// expected line controls for a mode and state
	function automatic cpmc_line_t exp_line(input logic s, input cpmc_det_t d,
		input cpmc_port_t p);
		cpmc_line_t l;
		l = LINE_RST;
		if (s)
		begin
			l.lines_short = (d != DET_DIVIDER);
			l.bias_2v7 = (d == DET_DIVIDER);
			l.bias_1v2 = (d == DET_SHORT12);
		end
		else
		begin
			l.data_sw_on = 1'b1;
			l.host_chg_sig = (p == PORT_CHG);
		end
		return l;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// all four outputs against one expected state
	task automatic chk_all(input logic s, input cpmc_det_t d,
		input cpmc_port_t p, input logic v);
		chk({3'h0, line_ctrl}, {3'h0, exp_line(s, d, p)});
		chk({6'h0, det_state}, {6'h0, d});
		chk({7'h0, port_state}, {7'h0, p});
		chk({7'h0, vbus_en}, {7'h0, v});
	endtask

	// settle a few edges past the synchroniser, sample off the edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task summarize();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard, run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			summarize();
		end
	end

	initial
	begin
		void'($urandom(66));
		{rst_n, strap, host, plug, compliant, talk} = 6'h00;
		@(posedge clk);
		@(negedge clk);
		chk({2'h0, line_ctrl, vbus_en}, 8'h00);
		@(posedge clk) rst_n <= 1'b1;
		$display("test reset done");
		@(posedge clk) {strap, plug} <= 2'b11;
		wt(6);
		chk_all(1'b1, DET_DIVIDER, PORT_CHG, 1'b1);
		@(posedge clk) compliant <= 1'b1;
		wt(6);
		chk_all(1'b1, DET_SHORTED, PORT_CHG, 1'b1);
		wt(SHORT_CYC - 20);
		chk_all(1'b1, DET_SHORTED, PORT_CHG, 1'b1);
		wt(30);
		chk_all(1'b1, DET_SHORT12, PORT_CHG, 1'b1);
		@(posedge clk) rst_n <= 1'b0;
		wt(2);
		chk({2'h0, line_ctrl, vbus_en}, 8'h00);
		@(posedge clk) {rst_n, compliant} <= 2'b10;
		wt(6);
		chk_all(1'b1, DET_DIVIDER, PORT_CHG, 1'b1);
		@(posedge clk) compliant <= 1'b1;
		wt(8);
		@(posedge clk) plug <= 1'b0;
		wt(6);
		chk_all(1'b1, DET_DIVIDER, PORT_CHG, 1'b1);
		$display("test auto done");
		@(posedge clk) {strap, plug, talk} <= 3'b011;
		// random host activity, traffic keeps the charging flavour
		repeat (8)
		begin
			@(posedge clk) host <= 1'($urandom % 2);
			wt(6);
			chk_all(1'b0, DET_DIVIDER, PORT_CHG, host);
		end
		@(posedge clk) {host, talk} <= 2'b10;
		wt(FB + 8);
		chk_all(1'b0, DET_DIVIDER, PORT_STD, 1'b1);
		@(posedge clk) plug <= 1'b0;
		wt(6);
		chk_all(1'b0, DET_DIVIDER, PORT_CHG, 1'b1);
		$display("test port done");
		summarize();
	end
endmodule

`default_nettype wire
